// file: rtl/dtg_pkg.sv
// constants, register map and field types of the tone generator control block
//
// Notes on behaviour
// - With the control-source select input high, frequency select, phase select, reset and converter sleep come from the dedicated pins.
// - With the control-source select input low, those four functions come from the software control bits instead.
// - Two independent frequency words, zero and one, are held and the host may load either of them.
// - The output frequency is the master clock divided by two to the 28th, times the selected frequency word.
// - The output phase is offset by two pi over 4096 times the selected phase word.
// - Two phase words, zero and one, are held and the host may load and select either of them.
// - A configuration bit chooses a sine or a ramp (triangle) output waveform.
// - A configuration bit enables or disables the comparator that forms the square-wave output.
// - With the comparator disabled, the sign output carries the accumulator MSB or that MSB divided by two, as configured.
// - Software can gate off the internal master clock in either mode, and in software mode power down the converter only, or both.
// - In pin mode, toggling the frequency select pin switches the output between word zero and word one.
// - A software reset command from the host resets the internal registers, beside the reset pin.
package dtg_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ACC_W   = 28;
  localparam int PHASE_W = 12;
  localparam int DAC_W   = 10;
  localparam int AMP_W   = 9;
  localparam int LUT_AW  = 4;
  localparam int ADR_W   = 8;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADR_W-1:0] OFS_FREQ0   = 8'h04;
  localparam logic [ADR_W-1:0] OFS_FREQ1   = 8'h08;
  localparam logic [ADR_W-1:0] OFS_PHASE0  = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_PHASE1  = 8'h10;
  localparam logic [ADR_W-1:0] OFS_COMMAND = 8'h14;
  localparam logic [ADR_W-1:0] OFS_STATUS  = 8'h18;
  localparam logic [ADR_W-1:0] OFS_ACCUM   = 8'h1c;

  // command register: soft reset bit
  localparam int CMD_SOFT_RESET_BIT = 0;

  // ----------------------------------------------------------------
  // control register layout (bits 7..0, upper bits read zero)
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sign_full_msb;  // 7: 1 = msb, 0 = msb divided by two
    logic comp_en;        // 6: comparator drives the sign output
    logic wave_ramp;      // 5: 1 = ramp, 0 = sine
    logic sleep_dac;      // 4: converter powered down
    logic sleep_mclk;     // 3: internal master clock gated off
    logic sw_reset;       // 2: hold accumulator in reset
    logic sw_phase_sel;   // 1
    logic sw_freq_sel;    // 0
  } dtg_ctrl_t;

  localparam int CTRL_W = $bits(dtg_ctrl_t);
  localparam dtg_ctrl_t CTRL_RESET = '{sign_full_msb: 1'b1, default: 1'b0};

  // live status word, bits 7..0
  typedef struct packed {
    logic pin_mode;
    logic acc_msb;
    logic sign_bit;
    logic dac_down;
    logic mclk_gated;
    logic reset_active;
    logic phase_sel;
    logic freq_sel;
  } dtg_status_t;

  localparam int STATUS_W = $bits(dtg_status_t);

  // ----------------------------------------------------------------
  // output coding
  // ----------------------------------------------------------------
  localparam logic [DAC_W-1:0] DAC_MID    = 10'h200;
  localparam logic [DAC_W-1:0] DAC_MID_M1 = 10'h1ff;

  // first quarter of the sine, sampled at bin centres, full scale 511
  localparam logic [AMP_W-1:0] SINE_QUARTER [16] = '{
    9'h019, 9'h04b, 9'h07c, 9'h0ac, 9'h0db, 9'h107, 9'h130, 9'h157,
    9'h17b, 9'h19a, 9'h1b6, 9'h1ce, 9'h1e1, 9'h1f0, 9'h1f9, 9'h1fe
  };

endpackage

// file: rtl/dtg_top.sv
// tone generator control: register slave, control source mux, accumulator, waveform and sign out
module dtg_top
(
  // clock and reset
  input  wire logic                        CLK_SYS_I,
  input  wire logic                        NRST_I,
  // wishbone classic slave
  input  wire logic                        WB_CYC_I,
  input  wire logic                        WB_STB_I,
  input  wire logic                        WB_WE_I,
  input  wire logic [dtg_pkg::ADR_W-1:0]   WB_ADR_I,
  input  wire logic [3:0]                  WB_SEL_I,
  input  wire logic [31:0]                 WB_DAT_I,
  output logic      [31:0]                 WB_DAT_O,
  output logic                             WB_ACK_O,
  // hardware control pins
  input  wire logic                        CONTROL_SOURCE_SELECT_I,
  input  wire logic                        FREQ_WORD_SELECT_PIN_I,
  input  wire logic                        PHASE_WORD_SELECT_PIN_I,
  input  wire logic                        RESET_PIN_I,
  input  wire logic                        SLEEP_PIN_I,
  // converter and sign outputs
  output logic      [dtg_pkg::DAC_W-1:0]   ANALOG_CURRENT_OUTPUT_O,
  output logic      [dtg_pkg::DAC_W-1:0]   ANALOG_CURRENT_OUTPUT_COMPLEMENT_O,
  output logic                             DAC_EN_O,
  output logic                             SIGN_BIT_O
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  dtg_pkg::dtg_ctrl_t                ctrl;
  logic [dtg_pkg::ACC_W-1:0]         freq_word_zero;
  logic [dtg_pkg::ACC_W-1:0]         freq_word_one;
  logic [dtg_pkg::PHASE_W-1:0]       phase_word_zero;
  logic [dtg_pkg::PHASE_W-1:0]       phase_word_one;
  logic [dtg_pkg::ACC_W-1:0]         acc;
  logic                              acc_msb_prev;
  logic                              msb_div2;
  logic [dtg_pkg::DAC_W-1:0]         dac_code;
  logic                              sign_bit;
  logic                              ack;

  logic                              wb_req;
  logic                              wb_wr;
  logic                              soft_reset;
  logic [31:0]                       rd_data;
  dtg_pkg::dtg_status_t              status;

  logic                              freq_sel;
  logic                              phase_sel;
  logic                              reset_active;
  logic                              mclk_gated;
  logic                              dac_down;
  logic [dtg_pkg::ACC_W-1:0]         selected_freq_word_value;
  logic [dtg_pkg::PHASE_W-1:0]       selected_phase_word_value;
  logic [dtg_pkg::ACC_W-1:0]         next_acc;
  logic [dtg_pkg::PHASE_W-1:0]       lookup_phase;
  logic [dtg_pkg::LUT_AW-1:0]        quarter_idx;
  logic [dtg_pkg::AMP_W-1:0]         amp;
  logic [dtg_pkg::DAC_W-1:0]         sine_code;
  logic [dtg_pkg::DAC_W-1:0]         ramp_code;
  logic [dtg_pkg::DAC_W-1:0]         next_dac_code;
  logic                              next_sign_bit;

  // byte-lane merge of a write into a 32-bit register image
  function automatic logic [31:0] merge_lanes
  (
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  sel
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ------------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------------
  // ack one cycle after the request, then low for a cycle so a held
  // request is answered at most every other cycle
  assign wb_req = WB_CYC_I && WB_STB_I && !ack;
  assign wb_wr  = wb_req && WB_WE_I;

  // software reset command: one write with the reset bit set
  assign soft_reset = wb_wr && (WB_ADR_I == dtg_pkg::OFS_COMMAND) &&
                      WB_SEL_I[0] && WB_DAT_I[dtg_pkg::CMD_SOFT_RESET_BIT];

  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= wb_req;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      WB_DAT_O <= 32'h0000_0000;
    end
    else if (wb_req && !WB_WE_I)
    begin
      WB_DAT_O <= rd_data;
    end
  end

  assign WB_ACK_O = ack;

  // ------------------------------------------------------------------
  // configuration and word registers
  // ------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      ctrl <= dtg_pkg::CTRL_RESET;
    end
    else if (soft_reset)
    begin
      ctrl <= dtg_pkg::CTRL_RESET;
    end
    else if (wb_wr && (WB_ADR_I == dtg_pkg::OFS_CTRL))
    begin
      ctrl <= dtg_pkg::dtg_ctrl_t'(dtg_pkg::CTRL_W'(merge_lanes(32'(ctrl), WB_DAT_I,
                                                                WB_SEL_I)));
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      freq_word_zero <= '0;
      freq_word_one  <= '0;
    end
    else if (soft_reset)
    begin
      freq_word_zero <= '0;
      freq_word_one  <= '0;
    end
    else if (wb_wr && (WB_ADR_I == dtg_pkg::OFS_FREQ0))
    begin
      freq_word_zero <= dtg_pkg::ACC_W'(merge_lanes(32'(freq_word_zero), WB_DAT_I,
                                                    WB_SEL_I));
    end
    else if (wb_wr && (WB_ADR_I == dtg_pkg::OFS_FREQ1))
    begin
      freq_word_one <= dtg_pkg::ACC_W'(merge_lanes(32'(freq_word_one), WB_DAT_I,
                                                   WB_SEL_I));
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      phase_word_zero <= '0;
      phase_word_one  <= '0;
    end
    else if (soft_reset)
    begin
      phase_word_zero <= '0;
      phase_word_one  <= '0;
    end
    else if (wb_wr && (WB_ADR_I == dtg_pkg::OFS_PHASE0))
    begin
      phase_word_zero <= dtg_pkg::PHASE_W'(merge_lanes(32'(phase_word_zero), WB_DAT_I,
                                                       WB_SEL_I));
    end
    else if (wb_wr && (WB_ADR_I == dtg_pkg::OFS_PHASE1))
    begin
      phase_word_one <= dtg_pkg::PHASE_W'(merge_lanes(32'(phase_word_one), WB_DAT_I,
                                                      WB_SEL_I));
    end
  end

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  assign status = '{pin_mode:     CONTROL_SOURCE_SELECT_I,
                    acc_msb:      acc[dtg_pkg::ACC_W-1],
                    sign_bit:     sign_bit,
                    dac_down:     dac_down,
                    mclk_gated:   mclk_gated,
                    reset_active: reset_active,
                    phase_sel:    phase_sel,
                    freq_sel:     freq_sel};

  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (WB_ADR_I)
      dtg_pkg::OFS_CTRL:    rd_data = 32'(ctrl);
      dtg_pkg::OFS_FREQ0:   rd_data = 32'(freq_word_zero);
      dtg_pkg::OFS_FREQ1:   rd_data = 32'(freq_word_one);
      dtg_pkg::OFS_PHASE0:  rd_data = 32'(phase_word_zero);
      dtg_pkg::OFS_PHASE1:  rd_data = 32'(phase_word_one);
      dtg_pkg::OFS_STATUS:  rd_data = 32'(status);
      dtg_pkg::OFS_ACCUM:   rd_data = 32'(acc);
      // command register and unmapped offsets read zero
      default:              rd_data = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------------
  // control source selection
  // ------------------------------------------------------------------
  // the sleep pin powers down the converter only; gating the master
  // clock stays a software choice in both modes
  always_comb
  begin
    if (CONTROL_SOURCE_SELECT_I)
    begin
      freq_sel     = FREQ_WORD_SELECT_PIN_I;
      phase_sel    = PHASE_WORD_SELECT_PIN_I;
      reset_active = RESET_PIN_I;
      dac_down     = SLEEP_PIN_I;
    end
    else
    begin
      freq_sel     = ctrl.sw_freq_sel;
      phase_sel    = ctrl.sw_phase_sel;
      reset_active = ctrl.sw_reset;
      dac_down     = ctrl.sleep_dac;
    end
    mclk_gated = ctrl.sleep_mclk;
  end

  // word selection follows the select level combinationally
  assign selected_freq_word_value  = freq_sel ? freq_word_one : freq_word_zero;
  assign selected_phase_word_value = phase_sel ? phase_word_one : phase_word_zero;

  // ------------------------------------------------------------------
  // phase accumulator
  // ------------------------------------------------------------------
  // wraps modulo 2^28, so fout = fclk * word / 2^28
  assign next_acc = acc + selected_freq_word_value;

  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      acc <= '0;
    end
    else if (soft_reset || reset_active)
    begin
      acc <= '0;
    end
    else if (!mclk_gated)
    begin
      acc <= next_acc;
    end
  end

  // divide-by-two of the msb: toggles on each rising msb edge
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      acc_msb_prev <= 1'b0;
      msb_div2     <= 1'b0;
    end
    else if (soft_reset || reset_active)
    begin
      acc_msb_prev <= 1'b0;
      msb_div2     <= 1'b0;
    end
    else if (!mclk_gated)
    begin
      acc_msb_prev <= acc[dtg_pkg::ACC_W-1];
      if (acc[dtg_pkg::ACC_W-1] && !acc_msb_prev)
      begin
        msb_div2 <= !msb_div2;
      end
    end
  end

  // ------------------------------------------------------------------
  // waveform lookup
  // ------------------------------------------------------------------
  // 12-bit phase offset added to the top accumulator bits
  // so one step is 2*pi/4096
  assign lookup_phase = acc[dtg_pkg::ACC_W-1 -: dtg_pkg::PHASE_W] +
                        selected_phase_word_value;

  // quarter-wave table mirrored per quadrant; only 16 points per quarter,
  // a coarse sine traded for area
  assign quarter_idx = lookup_phase[dtg_pkg::PHASE_W-2] ?
                       ~lookup_phase[dtg_pkg::PHASE_W-3 -: dtg_pkg::LUT_AW] :
                        lookup_phase[dtg_pkg::PHASE_W-3 -: dtg_pkg::LUT_AW];
  assign amp = dtg_pkg::SINE_QUARTER[quarter_idx];

  assign sine_code = lookup_phase[dtg_pkg::PHASE_W-1] ?
                     (dtg_pkg::DAC_MID_M1 - dtg_pkg::DAC_W'(amp)) :
                     (dtg_pkg::DAC_MID + dtg_pkg::DAC_W'(amp));

  // triangle: rises over the first half cycle and falls over the second
  assign ramp_code = lookup_phase[dtg_pkg::PHASE_W-1] ?
                     ~lookup_phase[dtg_pkg::PHASE_W-2 -: dtg_pkg::DAC_W] :
                      lookup_phase[dtg_pkg::PHASE_W-2 -: dtg_pkg::DAC_W];

  always_comb
  begin
    if (reset_active || dac_down)
    begin
      next_dac_code = dtg_pkg::DAC_MID;
    end
    else if (ctrl.wave_ramp)
    begin
      next_dac_code = ramp_code;
    end
    else
    begin
      next_dac_code = sine_code;
    end
  end

  // comparator models a square wave from the generated waveform; it
  // needs the converter path, so next_sign_bit is low while that is down
  always_comb
  begin
    if (ctrl.comp_en)
    begin
      next_sign_bit = !dac_down && next_dac_code[dtg_pkg::DAC_W-1];
    end
    else if (ctrl.sign_full_msb)
    begin
      next_sign_bit = acc[dtg_pkg::ACC_W-1];
    end
    else
    begin
      next_sign_bit = msb_div2;
    end
  end

  // ------------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      dac_code <= dtg_pkg::DAC_MID;
    end
    else if (soft_reset)
    begin
      dac_code <= dtg_pkg::DAC_MID;
    end
    else if (!mclk_gated || reset_active || dac_down)
    begin
      dac_code <= next_dac_code;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      sign_bit <= 1'b0;
    end
    else if (soft_reset)
    begin
      sign_bit <= 1'b0;
    end
    else if (!mclk_gated || reset_active)
    begin
      sign_bit <= next_sign_bit; // kept alive while only the converter sleeps
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      DAC_EN_O <= 1'b0;
    end
    else
    begin
      DAC_EN_O <= !dac_down;
    end
  end

  assign ANALOG_CURRENT_OUTPUT_O            = dac_code;
  assign ANALOG_CURRENT_OUTPUT_COMPLEMENT_O = ~dac_code;
  assign SIGN_BIT_O                         = sign_bit;

endmodule

// file: verif/dtg_assertions.sv
// port-level assertion checker for the tone generator control block
module dtg_chk
(
  // clock and reset
  input wire logic                      CLK_SYS_I,
  input wire logic                      NRST_I,
  // register bus
  input wire logic                      WB_CYC_I,
  input wire logic                      WB_STB_I,
  input wire logic                      WB_WE_I,
  input wire logic [31:0]               WB_DAT_O,
  input wire logic                      WB_ACK_O,
  // pins and converter
  input wire logic                      CONTROL_SOURCE_SELECT_I,
  input wire logic                      RESET_PIN_I,
  input wire logic                      SLEEP_PIN_I,
  input wire logic [dtg_pkg::DAC_W-1:0] ANALOG_CURRENT_OUTPUT_O,
  input wire logic [dtg_pkg::DAC_W-1:0] ANALOG_CURRENT_OUTPUT_COMPLEMENT_O,
  input wire logic                      DAC_EN_O
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!NRST_I);

  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence

  sequence s_pin_reset;
    CONTROL_SOURCE_SELECT_I && RESET_PIN_I;
  endsequence

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_next: assert property (s_req |=> WB_ACK_O)
    else $error("request not answered in the next cycle");
  a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I && !WB_ACK_O))
    else $error("ack without a request");
  a_dat_hold: assert property (!(WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O)
                               |=> $stable(WB_DAT_O))
    else $error("read data changed without a read");
  a_code_pair: assert property (ANALOG_CURRENT_OUTPUT_COMPLEMENT_O
                                == ~ANALOG_CURRENT_OUTPUT_O)
    else $error("complement output not inverse of output");
  a_off_mid: assert property (!DAC_EN_O |-> ANALOG_CURRENT_OUTPUT_O == dtg_pkg::DAC_MID)
    else $error("converter off but code not midscale");
  a_sleep_pin: assert property (CONTROL_SOURCE_SELECT_I && SLEEP_PIN_I |=> !DAC_EN_O)
    else $error("sleep pin did not power down converter");
  a_reset_pin: assert property (s_pin_reset |=> ANALOG_CURRENT_OUTPUT_O == dtg_pkg::DAC_MID)
    else $error("reset pin did not force midscale");
endmodule

bind dtg_top dtg_chk u_chk
(
  .CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .CONTROL_SOURCE_SELECT_I(CONTROL_SOURCE_SELECT_I), .RESET_PIN_I(RESET_PIN_I),
  .SLEEP_PIN_I(SLEEP_PIN_I), .ANALOG_CURRENT_OUTPUT_O(ANALOG_CURRENT_OUTPUT_O),
  .ANALOG_CURRENT_OUTPUT_COMPLEMENT_O(ANALOG_CURRENT_OUTPUT_COMPLEMENT_O),
  .DAC_EN_O(DAC_EN_O)
);

// file: verif/dtg_host.sv
// host model: register bus master, control pin driver and frequency sweep
module dtg_host
(
  // clock
  input  wire logic        clk_i,
  // register bus
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o,
  input  wire logic        ack_i,
  // pins: source, freq sel, phase sel, reset, sleep
  output logic [4:0]       pins_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
    pins_o = 5'h00;
  end

  // called just after a rising edge; returns on an edge after one idle cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    do
      @(posedge clk_i);
    while (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // released lines must not look like the last request
    adr_o <= ~a;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask

  task automatic drive_pins(input logic [4:0] p);
    pins_o <= p;
  endtask

  task automatic sweep(input int start, input int stop, input int inc,
                       input int loops, input int gap);
    repeat (loops)
      for (int f = start; f <= stop; f += inc)
      begin
        bus(1'b1, dtg_pkg::OFS_FREQ0, 32'(f), 4'hf);
        repeat (gap) @(posedge clk_i);
      end
  endtask
endmodule

// file: verif/dtg_top_tb.sv
// self-checking bench for the tone generator control block
module dtg_top_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc, stb, we, ack, dac_en, sign;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_w, dat_r, f, c, p, e;
  logic [4:0]  pins;
  logic [9:0]  code;
  logic [11:0] ph;
  logic [7:0]  ctl [4] = '{8'h80, 8'h82, 8'ha0, 8'he2};
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          mismatches = 0;
  int          samples_checked = 0;
  int          seed = 32'h66d89e7d;

  always #50 clk_sys = ~clk_sys;

  dtg_top dut
  (
    .CLK_SYS_I(clk_sys), .NRST_I(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
    .CONTROL_SOURCE_SELECT_I(pins[4]), .FREQ_WORD_SELECT_PIN_I(pins[3]),
    .PHASE_WORD_SELECT_PIN_I(pins[2]), .RESET_PIN_I(pins[1]), .SLEEP_PIN_I(pins[0]),
    .ANALOG_CURRENT_OUTPUT_O(code), .ANALOG_CURRENT_OUTPUT_COMPLEMENT_O(),
    .DAC_EN_O(dac_en), .SIGN_BIT_O(sign)
  );

  dtg_host host
  (
    .clk_i(clk_sys), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .dat_o(dat_w), .ack_i(ack), .pins_o(pins)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back(x & m);
    msk_q.push_back(m);
    host.bus(1'b0, a, $random(seed), 4'hf);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    host.bus(1'b1, a, d, s);
  endtask

  task automatic defaults;
    for (int a = 0; a <= 'h24; a += 4)
      rd(8'(a), (a == 0) ? 32'h80 : 32'h0, 32'hffffffff);
  endtask

  task automatic end_sim;
    // a read that never came back is a failure too
    if (exp_q.size() != 0)
      mismatches++;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // reads are compared in the order they were issued
  always @(posedge clk_sys)
  begin
    if (nrst && ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      chk("read data", exp_q.pop_front(), dat_r & msk_q.pop_front());
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    end_sim();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    defaults();
    // byte lanes and word widths
    for (int i = 0; i < 4; i++)
    begin
      f = $random(seed);
      c = $random(seed);
      p = (i < 2) ? 32'h0fffffff : 32'h00000fff;
      wr(8'(4 + 4 * i), f, 4'hf);
      wr(8'(4 + 4 * i), c, 4'b0101);
      rd(8'(4 + 4 * i), {f[31:24], c[23:16], f[15:8], c[7:0]}, p);
    end
    wr(8'h20, f, 4'hf);
    // accumulator steps by the word, then freezes with the clock gated
    f = $random(seed) & 32'h0fffffff;
    wr(dtg_pkg::OFS_CTRL, 32'h84, 4'h1);
    wr(dtg_pkg::OFS_FREQ0, f, 4'hf);
    wr(dtg_pkg::OFS_CTRL, 32'h80, 4'h1);
    rd(dtg_pkg::OFS_ACCUM, 2 * f, 32'h0fffffff);
    rd(dtg_pkg::OFS_ACCUM, 5 * f, 32'h0fffffff);
    wr(dtg_pkg::OFS_CTRL, 32'h88, 4'h1);
    rd(dtg_pkg::OFS_ACCUM, 9 * f, 32'h0fffffff);
    rd(dtg_pkg::OFS_ACCUM, 9 * f, 32'h0fffffff);
    wr(dtg_pkg::OFS_CTRL, 32'h80, 4'h1);
    // pin mode picks word one and releases the accumulator
    f = $random(seed) & 32'h0fffffff;
    wr(dtg_pkg::OFS_FREQ1, f, 4'hf);
    host.drive_pins(5'h1a);
    @(posedge clk_sys);
    host.drive_pins(5'h18);
    rd(dtg_pkg::OFS_ACCUM, 32'h0, 32'h0fffffff);
    rd(dtg_pkg::OFS_ACCUM, 3 * f, 32'h0fffffff);
    // control source: pins against software bits
    for (int i = 0; i < 8; i++)
    begin
      c = $random(seed);
      p = $random(seed);
      p[4] = i[0];
      if (i == 7)
        p = 32'h1f;
      wr(dtg_pkg::OFS_CTRL, {24'h0, 5'h10, c[2:0]}, 4'h1);
      host.drive_pins(p[4:0]);
      e = {24'h0, p[4], 2'b00, p[4] & p[0], 1'b0, p[4] ? {p[1], p[2], p[3]} : c[2:0]};
      rd(dtg_pkg::OFS_STATUS, e, 32'h9f);
    end
    host.drive_pins(5'h00);
    wr(dtg_pkg::OFS_COMMAND, 32'h1, 4'h1);
    defaults();
    // phase offset, waveform, comparator and sign source
    for (int i = 0; i < 4; i++)
    begin
      ph = (i < 2) ? 12'(i * 'h800) : 12'($random(seed));
      wr(8'(dtg_pkg::OFS_PHASE0 + 4 * (i % 2)), {20'h0, ph}, 4'h3);
      wr(dtg_pkg::OFS_CTRL, {24'h0, ctl[i]}, 4'h1);
      e = (i < 2) ? (ph[11] ? 32'h1e6 : 32'h219) : {22'h0, ph[11] ? ~ph[10:1] : ph[10:1]};
      repeat (4) @(posedge clk_sys);
      chk("converter code", e, 32'(code));
      chk("sign output", 32'(i == 3 && e[9]), 32'(sign));
    end
    wr(dtg_pkg::OFS_CTRL, 32'h90, 4'h1);
    repeat (2) @(posedge clk_sys);
    chk("converter enable", 32'h0, 32'(dac_en));
    host.sweep('h100, 'h400, 'h100, 2, 3);
    rd(dtg_pkg::OFS_FREQ0, 32'h400, 32'hffffffff);
    // sign source: a quarter-range word makes the msb rise every 4 cycles,
    // so 32 cycles hold 8 rises of the msb and 4 of the msb over two
    wr(dtg_pkg::OFS_FREQ0, 32'h0400_0000, 4'hf);
    for (int i = 0; i < 2; i++)
    begin
      wr(dtg_pkg::OFS_CTRL, (i == 0) ? 32'h80 : 32'h00, 4'h1);
      repeat (8) @(posedge clk_sys);
      c = 32'(sign);
      e = 32'h0;
      repeat (32)
      begin
        @(posedge clk_sys);
        e = e + 32'(sign && !c[0]);
        c = 32'(sign);
      end
      chk("sign rising edges", (i == 0) ? 32'h8 : 32'h4, e);
    end
    end_sim();
  end
endmodule
